// *** design/rcc_regs.sv ***
`timescale 1ns/1ps
// Notes on behaviour
// - Channel 1 target voltage code is seven bits, read and write, bits 6..0.
// - Codes below 0x30 map at 25 mV per step from 0.500 V.
// - Codes 0x30 to 0x7c map at 50 mV per step from 1.700 V to 5.500 V.
// - Channel 2 has its own seven-bit code with the same mapping.
// - Control bit 6 picks topology: 0 buck-boost, 1 buck only.
// - Discharge bit 0 means no internal discharge load when channel is off.
// - Discharge bit 1 connects internal resistor to power ground while channel is off.
// - Enable values 0..3 put the channel in sequencer slot 0..3.
// - Enable values 4 and 5 force the channel off.
// - Enable values 6 and 7 force the channel on.
module rcc_regs (
   input wire logic clk_i,
   input wire logic nrst_i,
   // Register port from the serial host interface
   input wire logic [7:0] reg_addr_i,
   input wire logic reg_wr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_rd_i,
   output logic [7:0] reg_rdata_o,
   output logic reg_rvalid_o,
   // Factory defaults
   input wire logic [6:0] otp_ch1_code_i,
   input wire logic [6:0] otp_ch2_code_i,
   input wire logic otp_topology_i,
   input wire logic otp_discharge_i,
   input wire logic [2:0] otp_enable_i,
   // Sequencer slot on/off levels
   input wire logic [3:0] seq_slot_on_i,
   // Configuration outputs toward the regulator
   output logic [6:0] ch1_target_voltage_code_o,
   output logic [6:0] ch2_target_voltage_code_o,
   output logic [12:0] ch1_target_mv_o,
   output logic [12:0] ch2_target_mv_o,
   output logic ch1_code_reserved_o,
   output logic ch2_code_reserved_o,
   output logic topology_select_o,
   output logic ch1_discharge_enable_o,
   output logic [2:0] ch1_sequencing_control_o,
   output logic ch1_enabled_o,
   output logic ch1_discharge_connect_o,
   output logic defaults_loaded_o
);

   // ==========================================================
   // Reset synchroniser
   // ==========================================================
   logic rst_meta_reg;
   logic rst_n_reg;

   // Assertion stays asynchronous so outputs go safe without a clock
   // Release is synchronous so no register leaves reset on a split edge
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         rst_meta_reg <= 1'b0;
         rst_n_reg <= 1'b0;
      end else begin
         rst_meta_reg <= 1'b1;
         rst_n_reg <= rst_meta_reg;
      end
   end

   // ==========================================================
   // Factory default load
   // ==========================================================
   logic load_pending_reg;

   // Trade-off: one dead cycle after reset in exchange for no reset-value muxing
   // Defaults are ports, so they cannot feed an async reset; take them on the first clock instead
   always_ff @(posedge clk_i or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         load_pending_reg <= 1'b1;
      end else begin
         load_pending_reg <= 1'b0;
      end
   end

   // ==========================================================
   // Register storage
   // ==========================================================
   logic [6:0] ch1_code_reg;
   logic [6:0] ch2_code_reg;
   logic reserved_bit_reg;
   logic topology_reg;
   logic discharge_reg;
   logic [2:0] enable_reg;
   logic wr_ch1v;
   logic wr_ch1c;
   logic wr_ch2v;

   // Addresses compare in full; aliases at other offsets would hide software bugs
   // Write decode; writes in the load cycle are lost to the defaults
   assign wr_ch1v = reg_wr_i && (reg_addr_i == rcc_pkg::CH1_VOLTAGE_CONFIG_ADDR);
   assign wr_ch1c = reg_wr_i && (reg_addr_i == rcc_pkg::CH1_CONTROL_CONFIG_ADDR);
   assign wr_ch2v = reg_wr_i && (reg_addr_i == rcc_pkg::CH2_VOLTAGE_CONFIG_ADDR);

   // Channel 1 voltage code; bit 7 has no storage
   always_ff @(posedge clk_i or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         ch1_code_reg <= rcc_pkg::VCODE_RESET;
      end else if (load_pending_reg) begin
         ch1_code_reg <= otp_ch1_code_i;
      end else if (wr_ch1v) begin
         ch1_code_reg <= reg_wdata_i[rcc_pkg::VCODE_MSB:rcc_pkg::VCODE_LSB];
      end
   end

   // Channel 2 voltage code
   always_ff @(posedge clk_i or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         ch2_code_reg <= rcc_pkg::VCODE_RESET;
      end else if (load_pending_reg) begin
         ch2_code_reg <= otp_ch2_code_i;
      end else if (wr_ch2v) begin
         ch2_code_reg <= reg_wdata_i[rcc_pkg::VCODE_MSB:rcc_pkg::VCODE_LSB];
      end
   end

   // Channel 1 control fields; bits 5 and 4 are not stored
   always_ff @(posedge clk_i or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         reserved_bit_reg <= rcc_pkg::RESERVED_BIT_RESET;
         topology_reg <= rcc_pkg::TOPOLOGY_RESET;
         discharge_reg <= rcc_pkg::DISCHARGE_RESET;
         enable_reg <= rcc_pkg::ENABLE_RESET;
      end else if (load_pending_reg) begin
         reserved_bit_reg <= rcc_pkg::RESERVED_BIT_RESET;
         topology_reg <= otp_topology_i;
         discharge_reg <= otp_discharge_i;
         enable_reg <= otp_enable_i;
      end else if (wr_ch1c) begin
         // Reserved bit is kept as written; software should write zero
         reserved_bit_reg <= reg_wdata_i[rcc_pkg::RESERVED_BIT_POS];
         topology_reg <= reg_wdata_i[rcc_pkg::TOPOLOGY_POS];
         discharge_reg <= reg_wdata_i[rcc_pkg::DISCHARGE_POS];
         enable_reg <= reg_wdata_i[rcc_pkg::ENABLE_MSB:rcc_pkg::ENABLE_LSB];
      end
   end

   // ==========================================================
   // Read path
   // ==========================================================
   logic [7:0] rdata_next;

   // Unused positions assemble as zero
   always_comb begin
      unique case (reg_addr_i)
         rcc_pkg::CH1_VOLTAGE_CONFIG_ADDR: rdata_next = {1'b0, ch1_code_reg};
         rcc_pkg::CH2_VOLTAGE_CONFIG_ADDR: rdata_next = {1'b0, ch2_code_reg};
         rcc_pkg::CH1_CONTROL_CONFIG_ADDR: begin
            rdata_next = {reserved_bit_reg, topology_reg, 2'b00, discharge_reg, enable_reg};
         end
         default: rdata_next = rcc_pkg::UNMAPPED_READ_VALUE;
      endcase
   end

   // Read and write in one cycle return the old value, since storage
   // updates on the same edge that registers the read data
   // Read data is registered; one cycle after the strobe
   always_ff @(posedge clk_i or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         reg_rdata_o <= 8'h00;
         reg_rvalid_o <= 1'b0;
      end else begin
         reg_rvalid_o <= reg_rd_i;
         if (reg_rd_i) begin
            reg_rdata_o <= rdata_next;
         end
      end
   end

   // ==========================================================
   // Voltage code mapping
   // ==========================================================
   // Limitation: the millivolt value only models the analog target
   // Reserved codes give zero so a downstream compare cannot mistake them
   // Products are cut to 13 bits on purpose; the top code needs 5500 mV
   function automatic logic [12:0] code_to_mv(input logic [6:0] code);
      logic [12:0] c;
      c = {6'h00, code};
      if (code > rcc_pkg::TOP_VALID_CODE) begin
         code_to_mv = rcc_pkg::RESERVED_CODE_MV;
      end else if (code < rcc_pkg::HIGH_SEG_CODE) begin
         code_to_mv = rcc_pkg::LOW_BASE_MV + 13'(c * rcc_pkg::LOW_STEP_MV);
      end else begin
         code_to_mv = rcc_pkg::HIGH_BASE_MV
            + 13'((c - {6'h00, rcc_pkg::HIGH_SEG_CODE}) * rcc_pkg::HIGH_STEP_MV);
      end
   endfunction : code_to_mv

   // ==========================================================
   // Channel enable and discharge
   // ==========================================================
   logic ch1_on_next;

   // Slot levels are taken as synchronous; a sequencer in another domain
   // must resynchronise them before this port
   // Forced codes override the sequencer; slot codes follow their slot level
   always_comb begin
      unique case (enable_reg)
         rcc_pkg::EN_FORCE_OFF_A, rcc_pkg::EN_FORCE_OFF_B: ch1_on_next = 1'b0;
         rcc_pkg::EN_FORCE_ON_A, rcc_pkg::EN_FORCE_ON_B: ch1_on_next = 1'b1;
         default: ch1_on_next = seq_slot_on_i[enable_reg[1:0]];
      endcase
   end

   // All configuration outputs are flopped for a clean analog interface
   always_ff @(posedge clk_i or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         ch1_target_voltage_code_o <= rcc_pkg::VCODE_RESET;
         ch2_target_voltage_code_o <= rcc_pkg::VCODE_RESET;
         ch1_target_mv_o <= rcc_pkg::LOW_BASE_MV;
         ch2_target_mv_o <= rcc_pkg::LOW_BASE_MV;
         ch1_code_reserved_o <= 1'b0;
         ch2_code_reserved_o <= 1'b0;
         topology_select_o <= rcc_pkg::TOPOLOGY_RESET;
         ch1_discharge_enable_o <= rcc_pkg::DISCHARGE_RESET;
         ch1_sequencing_control_o <= rcc_pkg::ENABLE_RESET;
         ch1_enabled_o <= 1'b0;
         ch1_discharge_connect_o <= 1'b0;
         defaults_loaded_o <= 1'b0;
      end else begin
         ch1_target_voltage_code_o <= ch1_code_reg;
         ch2_target_voltage_code_o <= ch2_code_reg;
         ch1_target_mv_o <= code_to_mv(ch1_code_reg);
         ch2_target_mv_o <= code_to_mv(ch2_code_reg);
         // Flags misuse only; the device still stores the code
         ch1_code_reserved_o <= (ch1_code_reg > rcc_pkg::TOP_VALID_CODE);
         ch2_code_reserved_o <= (ch2_code_reg > rcc_pkg::TOP_VALID_CODE);
         topology_select_o <= topology_reg;
         ch1_discharge_enable_o <= discharge_reg;
         ch1_sequencing_control_o <= enable_reg;
         ch1_enabled_o <= ch1_on_next;
         // Resistor only while off and enabled; never while the channel drives
         ch1_discharge_connect_o <= discharge_reg && !ch1_on_next;
         defaults_loaded_o <= !load_pending_reg;
      end
   end

endmodule : rcc_regs

// *** include/rcc_pkg.sv ***
package rcc_pkg;

   // ==========================================================
   // Register map
   // ==========================================================
   localparam logic [7:0] CH1_VOLTAGE_CONFIG_ADDR = 8'h2b;
   localparam logic [7:0] CH1_CONTROL_CONFIG_ADDR = 8'h2c;
   localparam logic [7:0] CH2_VOLTAGE_CONFIG_ADDR = 8'h2d;
   localparam logic [7:0] UNMAPPED_READ_VALUE = 8'h00;

   // ==========================================================
   // Field layout
   // ==========================================================
   localparam int VCODE_MSB = 6;
   localparam int VCODE_LSB = 0;
   localparam int VCODE_W = 7;
   localparam int RESERVED_BIT_POS = 7;
   localparam int TOPOLOGY_POS = 6;
   localparam int DISCHARGE_POS = 3;
   localparam int ENABLE_MSB = 2;
   localparam int ENABLE_LSB = 0;
   localparam int ENABLE_W = 3;
   localparam int SLOT_COUNT = 4;

   // ==========================================================
   // Reset values of the register copies
   // ==========================================================
   localparam logic [6:0] VCODE_RESET = 7'h00;
   localparam logic RESERVED_BIT_RESET = 1'b0;
   localparam logic TOPOLOGY_RESET = 1'b0;
   localparam logic DISCHARGE_RESET = 1'b0;
   localparam logic [2:0] ENABLE_RESET = 3'h4;

   // ==========================================================
   // Enable field decode
   // ==========================================================
   localparam logic [2:0] EN_SLOT0 = 3'h0;
   localparam logic [2:0] EN_SLOT3 = 3'h3;
   localparam logic [2:0] EN_FORCE_OFF_A = 3'h4;
   localparam logic [2:0] EN_FORCE_OFF_B = 3'h5;
   localparam logic [2:0] EN_FORCE_ON_A = 3'h6;
   localparam logic [2:0] EN_FORCE_ON_B = 3'h7;

   // ==========================================================
   // Voltage code mapping, millivolts
   // ==========================================================
   localparam int MV_W = 13;
   localparam logic [12:0] LOW_BASE_MV = 13'h01f4;   // 500 mV at code 0x00
   localparam logic [12:0] LOW_STEP_MV = 13'h0019;   // 25 mV
   localparam logic [12:0] HIGH_BASE_MV = 13'h06a4;  // 1700 mV at code 0x30
   localparam logic [12:0] HIGH_STEP_MV = 13'h0032;  // 50 mV
   localparam logic [6:0] HIGH_SEG_CODE = 7'h30;
   localparam logic [6:0] TOP_VALID_CODE = 7'h7c;
   localparam logic [12:0] RESERVED_CODE_MV = 13'h0000;

endpackage : rcc_pkg

// *** bench/rcc_regs_asserts.sv ***
`timescale 1ns/1ps
// ==========================================================
// Register bank checker
module rcc_regs_asserts (
   input wire logic clk_i,
   input wire logic nrst_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic reg_wr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_rd_i,
   input wire logic [7:0] reg_rdata_o,
   input wire logic reg_rvalid_o,
   input wire logic [3:0] seq_slot_on_i,
   input wire logic [6:0] ch1_target_voltage_code_o,
   input wire logic [6:0] ch2_target_voltage_code_o,
   input wire logic [12:0] ch1_target_mv_o,
   input wire logic topology_select_o,
   input wire logic ch1_discharge_enable_o,
   input wire logic [2:0] ch1_sequencing_control_o,
   input wire logic ch1_enabled_o,
   input wire logic ch1_discharge_connect_o,
   input wire logic defaults_loaded_o
);
   logic [3:0] seq_q;
   logic [6:0] c1;
   // Slot levels as the enable logic saw them, so decode and check line up
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) seq_q <= 4'h0;
      else seq_q <= seq_slot_on_i;
   end
   assign c1 = ch1_target_voltage_code_o;
   default clocking @(posedge clk_i); endclocking
   default disable iff (!nrst_i);
   // ==========================================================
   // Properties; a write shows two edges on unless overwritten meanwhile
   code_write_a: assert property (defaults_loaded_o && reg_wr_i && reg_addr_i == 8'h2b
      ##1 !(reg_wr_i && reg_addr_i == 8'h2b) |=> c1 == $past(reg_wdata_i[6:0], 2))
      else $error("ch1 code write lost");
   ch2_write_a: assert property (defaults_loaded_o && reg_wr_i && reg_addr_i == 8'h2d
      ##1 !(reg_wr_i && reg_addr_i == 8'h2d) |=> ch2_target_voltage_code_o == $past(reg_wdata_i[6:0], 2))
      else $error("ch2 code write lost");
   ctl_write_a: assert property (defaults_loaded_o && reg_wr_i && reg_addr_i == 8'h2c
      ##1 !(reg_wr_i && reg_addr_i == 8'h2c) |=> {topology_select_o, ch1_discharge_enable_o,
      ch1_sequencing_control_o} == $past({reg_wdata_i[6], reg_wdata_i[3:0]}, 2)) else $error("control write lost");
   map_low_a: assert property (defaults_loaded_o && c1 < 7'h30 |->
      ch1_target_mv_o == 13'h1f4 + 13'h19 * c1) else $error("low segment mapping wrong");
   map_high_a: assert property (defaults_loaded_o && c1 inside {[7'h30:7'h7c]} |->
      ch1_target_mv_o == 13'h6a4 + 13'h32 * (c1 - 7'h30)) else $error("high segment mapping wrong");
   en_decode_a: assert property (defaults_loaded_o |-> ch1_enabled_o == (ch1_sequencing_control_o[2] ?
      ch1_sequencing_control_o[1] : seq_q[ch1_sequencing_control_o[1:0]])) else $error("enable decode wrong");
   disch_conn_a: assert property (defaults_loaded_o |->
      ch1_discharge_connect_o == (ch1_discharge_enable_o && !ch1_enabled_o)) else $error("discharge wrong");
   rd_valid_a: assert property (defaults_loaded_o |-> reg_rvalid_o == $past(reg_rd_i))
      else $error("read valid timing wrong");
   top_bit_a: assert property (reg_rd_i && reg_addr_i != 8'h2c |=> !reg_rdata_o[7])
      else $error("unused bit 7 read nonzero");
   ctl_gap_a: assert property (reg_rd_i && reg_addr_i == 8'h2c |=> reg_rdata_o[5:4] == 2'h0)
      else $error("unused control bits read nonzero");
endmodule : rcc_regs_asserts

bind rcc_regs rcc_regs_asserts u_asserts (.*);

// *** bench/rcc_regs_tb_top.sv ***
`timescale 1ns/1ps
// ==========================================================
// Signals and design
module rcc_regs_tb_top;
   logic clk_i, nrst_i, reg_wr_i, reg_rd_i, reg_rvalid_o, otp_topology_i, otp_discharge_i;
   logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o;
   logic [6:0] otp_ch1_code_i, otp_ch2_code_i, ch1_target_voltage_code_o, ch2_target_voltage_code_o;
   logic [2:0] otp_enable_i, ch1_sequencing_control_o;
   logic [3:0] seq_slot_on_i;
   logic [12:0] ch1_target_mv_o, ch2_target_mv_o;
   logic ch1_code_reserved_o, ch2_code_reserved_o, topology_select_o, ch1_discharge_enable_o;
   logic ch1_enabled_o, ch1_discharge_connect_o, defaults_loaded_o;
   int error_cnt = 0;
   int num_checks = 0;
   rcc_regs dut (.*);
   // 20 MHz clock
   initial begin
      clk_i = 1'b0;
      forever #25 clk_i = ~clk_i;
   end
   // ==========================================================
   // Shared tasks; all start and end on a falling edge
   task automatic test_done();
      if (error_cnt == 0 && num_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : test_done
   task automatic chk(input logic [15:0] exp, input logic [15:0] got);
      num_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("Error at %0t: expected %h got %h", $time, exp, got);
      end
   endtask : chk
   // Extra edge at the end so the config outputs have settled
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      reg_addr_i = a;
      reg_wdata_i = d;
      reg_wr_i = 1'b1;
      @(negedge clk_i);
      reg_wr_i = 1'b0;
      @(negedge clk_i);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      reg_addr_i = a;
      reg_rd_i = 1'b1;
      @(negedge clk_i);
      reg_rd_i = 1'b0;
      chk({8'h01, exp}, {7'h00, reg_rvalid_o, reg_rdata_o});
      @(negedge clk_i);
   endtask : rd
   function automatic logic [12:0] mv(input logic [6:0] c);
      if (c < 7'h30) return 13'h1f4 + 13'h19 * c;
      if (c <= 7'h7c) return 13'h6a4 + 13'h32 * (c - 7'h30);
      return 13'h0000;
   endfunction : mv
   // ==========================================================
   // Scenarios
   task automatic t_reset(input logic [6:0] c1, input logic [6:0] c2, input logic [4:0] ctl);
      nrst_i = 1'b0;
      {otp_ch1_code_i, otp_ch2_code_i} = {c1, c2};
      {otp_topology_i, otp_discharge_i, otp_enable_i} = ctl;
      repeat (8) @(negedge clk_i);
      nrst_i = 1'b1;
      repeat (6) @(negedge clk_i);
      chk({2'h0, c1, c2}, {2'h0, ch1_target_voltage_code_o, ch2_target_voltage_code_o});
      rd(8'h2c, {1'b0, ctl[4], 2'h0, ctl[3:0]});
      rd(8'h2b, {1'b0, c1});
   endtask : t_reset
   // Segment edges and reserved codes; ch2 gets the complement to prove independence
   task automatic t_volt();
      logic [6:0] codes [6] = '{7'h00, 7'h2f, 7'h30, 7'h31, 7'h7c, 7'h7d};
      foreach (codes[i]) begin
         wr(8'h2b, {1'b1, codes[i]});
         wr(8'h2d, {1'b1, ~codes[i]});
         chk({2'h0, codes[i] > 7'h7c, mv(codes[i])}, {2'h0, ch1_code_reserved_o, ch1_target_mv_o});
         chk({2'h0, ~codes[i] > 7'h7c, mv(~codes[i])}, {2'h0, ch2_code_reserved_o, ch2_target_mv_o});
         rd(8'h2b, {1'b0, codes[i]});
         rd(8'h2d, {1'b0, ~codes[i]});
      end
   endtask : t_volt
   task automatic t_ctl();
      logic [2:0] en;
      logic on;
      for (int i = 0; i < 16; i++) begin
         en = i[2:0];
         seq_slot_on_i = i[3] ? 4'ha : 4'h5;
         on = en[2] ? en[1] : seq_slot_on_i[en[1:0]];
         wr(8'h2c, {1'b0, i[0], 2'h3, i[3], en});
         chk({9'h000, i[0], on, i[3] & !on, i[3], en}, {9'h000, topology_select_o, ch1_enabled_o,
            ch1_discharge_connect_o, ch1_discharge_enable_o, ch1_sequencing_control_o});
      end
      // Slot powering up later must switch the channel on and drop discharge
      wr(8'h2c, 8'h0a);
      chk(16'h0001, {14'h0000, ch1_enabled_o, ch1_discharge_connect_o});
      seq_slot_on_i = 4'h4;
      @(negedge clk_i);
      chk(16'h0002, {14'h0000, ch1_enabled_o, ch1_discharge_connect_o});
      rd(8'h2c, 8'h0a);
   endtask : t_ctl
   task automatic t_unmap();
      wr(8'h2e, 8'h55);
      wr(8'h2a, 8'h55);
      rd(8'h2e, 8'h00);
      rd(8'h2b, 8'h7d);
   endtask : t_unmap
   // Main sequence, ending with a reset in mid-run
   initial begin
      {reg_wr_i, reg_rd_i, reg_addr_i, reg_wdata_i, seq_slot_on_i} = '0;
      t_reset(7'h14, 7'h6b, 5'h16);
      t_volt();
      t_ctl();
      t_unmap();
      t_reset(7'h7c, 7'h00, 5'h0f);
      test_done();
   end
   // Watchdog, about fifteen times the expected run
   initial begin
      #100000;
      error_cnt++;
      test_done();
   end
endmodule : rcc_regs_tb_top
